//--- include/afmt_pkg.sv
`default_nettype none

package afmt_pkg;

    // Bus geometry
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;

    // Register byte offsets
    localparam logic [AXI_AW-1:0] OFS_FORMAT = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_RATE   = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_X      = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_Y      = 8'h0c;
    localparam logic [AXI_AW-1:0] OFS_Z      = 8'h10;
    localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h14;

    // Field positions
    localparam int FMT_RANGE_LSB = 0;
    localparam int FMT_JUST_BIT  = 2;
    localparam int FMT_FULL_BIT  = 3;
    localparam int RATE_LSB      = 0;
    localparam int STAT_RDY_BIT  = 0;
    localparam int STAT_OVR_BIT  = 1;

    // Reset values
    localparam logic [1:0] RANGE_RST = 2'h0;
    localparam logic       JUST_RST  = 1'h0;
    localparam logic       FULL_RST  = 1'h0;
    localparam logic [3:0] RATE_RST  = 4'ha;

    // Rate codes of the two highest output rates, 3200 Hz and 1600 Hz
    localparam logic [3:0] RATE_3200 = 4'hf;
    localparam logic [3:0] RATE_1600 = 4'he;

    // Word geometry
    localparam int         RAW_W      = 13;
    localparam int         WORD_W     = 16;
    localparam logic [3:0] BASE_W     = 4'ha;
    localparam logic [2:0] LJ_LSB_POS = 3'h6;
    localparam logic [1:0] RANGE_MAX  = 2'h3;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic signed [RAW_W-1:0] x;
        logic signed [RAW_W-1:0] y;
        logic signed [RAW_W-1:0] z;
    } afmt_sample_t;

    typedef struct packed {
        logic       full_res;
        logic       left_just;
        logic [1:0] range;
        logic [3:0] rate;
    } afmt_cfg_t;

    function automatic logic afmt_high_rate(input logic [3:0] rate);
        return (rate == RATE_3200) || (rate == RATE_1600);
    endfunction

endpackage

`default_nettype wire

//--- logic/afmt_word_fmt.sv
`default_nettype none

module afmt_word_fmt (
    // Raw sample at the fixed fine scale
    input  wire logic signed [afmt_pkg::RAW_W-1:0]  raw_in,
    // Format selection
    input  wire afmt_pkg::afmt_cfg_t                cfg_in,
    // Formatted word
    output logic             [afmt_pkg::WORD_W-1:0] word_out
);
    import afmt_pkg::*;

    // Saturate to a signed field of the given width
    function automatic logic signed [RAW_W-1:0] clamp(
        input logic signed [RAW_W-1:0] v,
        input logic [3:0]              bits
    );
        logic signed [RAW_W:0] hi;
        logic signed [RAW_W:0] lo;
        logic signed [RAW_W:0] ve;
        hi = (14'sd1 <<< (bits - 4'd1)) - 14'sd1;
        lo = -hi - 14'sd1;
        ve = {v[RAW_W-1], v};
        if (ve > hi)
            return hi[RAW_W-1:0];
        else if (ve < lo)
            return lo[RAW_W-1:0];
        else
            return v;
    endfunction

    logic [1:0]              shift;
    logic [3:0]              width;
    logic [2:0]              lj_shift;
    logic signed [RAW_W-1:0] val;
    logic [WORD_W-1:0]       ext;

    always_comb
    begin
        // Full resolution keeps the fine step; 10-bit drops bits per range
        shift = cfg_in.full_res ? 2'd0 : cfg_in.range; // R1
        width = cfg_in.full_res ? 4'(BASE_W + {2'b0, cfg_in.range}) : BASE_W;
        val   = clamp(raw_in >>> shift, width);
        if (afmt_high_rate(cfg_in.rate) &&
            (cfg_in.full_res || cfg_in.range == 2'h0))
        begin
            val[0] = 1'b0; // R2
        end
        // Other modes and slower rates keep a live lowest bit
        ext = {{(WORD_W-RAW_W){val[RAW_W-1]}}, val}; // R6 R7 R3
        lj_shift = cfg_in.full_res ? 3'(LJ_LSB_POS - {1'b0, cfg_in.range})
                                   : LJ_LSB_POS; // R4 R5
        if (cfg_in.left_just)
            word_out = ext << lj_shift;
        else
            word_out = ext;
    end

endmodule // afmt_word_fmt

`default_nettype wire

//--- logic/afmt_top.sv
// Summary of operation
// R1: Full resolution keeps one fixed acceleration step per bit in all ranges.
// R2: Top two rates, full-res or smallest 10-bit range: lowest bit is zero.
// R3: Right justified words put the lowest bit at bit zero of low byte.
// R4: Left justified smallest-range 10-bit puts lowest bit at bit six.
// R5: Left justified full-res lowest bit sits at bit 6,5,4,3 by range.
// R6: Top rates, 10-bit larger ranges: lowest bit stays live, not forced.
// R7: At 800 Hz or slower the lowest bit is live in every mode.
// R8: Range code three selects the largest range; separate bit picks full-res.
`default_nettype none

module afmt_top (
    // Clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         rst_in,
    // Sample stream
    input  wire logic                         sample_valid_in,
    input  wire afmt_pkg::afmt_sample_t       sample_in,
    // Write address channel
    input  wire logic                         s_axi_awvalid_in,
    output logic                              s_axi_awready_out,
    input  wire logic [afmt_pkg::AXI_AW-1:0]  s_axi_awaddr_in,
    // Write data channel
    input  wire logic                         s_axi_wvalid_in,
    output logic                              s_axi_wready_out,
    input  wire logic [afmt_pkg::AXI_DW-1:0]  s_axi_wdata_in,
    input  wire logic [3:0]                   s_axi_wstrb_in,
    // Write response channel
    output logic                              s_axi_bvalid_out,
    input  wire logic                         s_axi_bready_in,
    output logic [1:0]                        s_axi_bresp_out,
    // Read address channel
    input  wire logic                         s_axi_arvalid_in,
    output logic                              s_axi_arready_out,
    input  wire logic [afmt_pkg::AXI_AW-1:0]  s_axi_araddr_in,
    // Read data channel
    output logic                              s_axi_rvalid_out,
    input  wire logic                         s_axi_rready_in,
    output logic [afmt_pkg::AXI_DW-1:0]       s_axi_rdata_out,
    output logic [1:0]                        s_axi_rresp_out,
    // Status
    output logic                              data_ready_out
);
    import afmt_pkg::*;

    afmt_cfg_t         cfg_ff;
    logic [WORD_W-1:0] word_ff [3];
    logic [WORD_W-1:0] nxt_word [3];
    logic              ready_ff;
    logic              ovr_ff;

    logic              awready_ff;
    logic              wready_ff;
    logic [AXI_AW-1:0] awaddr_ff;
    logic [AXI_DW-1:0] wdata_ff;
    logic [3:0]        wstrb_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              arready_ff;
    logic              rvalid_ff;
    logic [AXI_DW-1:0] rdata_ff;
    logic [1:0]        rresp_ff;

    logic              aw_hs;
    logic              w_hs;
    logic              wr_fire;
    logic              ar_hs;
    logic              stat_rd;
    logic [AXI_DW-1:0] rd_data;
    logic              rd_err;
    logic [RAW_W-1:0]  raw [3];

    assign raw[0] = sample_in.x;
    assign raw[1] = sample_in.y;
    assign raw[2] = sample_in.z;

    // One formatter per axis, all sharing the current selection
    for (genvar i = 0; i < 3; i++)
    begin : g_axis
        afmt_word_fmt u_fmt (
            .raw_in   (raw[i]),
            .cfg_in   (cfg_ff),
            .word_out (nxt_word[i])
        );
    end

    // Address stays held while the response is outstanding
    assign aw_hs   = s_axi_awvalid_in && awready_ff;
    assign w_hs    = s_axi_wvalid_in && wready_ff;
    assign wr_fire = !awready_ff && !wready_ff && !bvalid_ff;
    assign ar_hs   = s_axi_arvalid_in && arready_ff;
    assign stat_rd = ar_hs && (s_axi_araddr_in == OFS_STATUS);

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            awready_ff <= 1'b1;
            awaddr_ff  <= '0;
        end
        else if (aw_hs)
        begin
            awready_ff <= 1'b0;
            awaddr_ff  <= s_axi_awaddr_in;
        end
        else if (bvalid_ff && s_axi_bready_in)
            awready_ff <= 1'b1;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            wready_ff <= 1'b1;
            wdata_ff  <= '0;
            wstrb_ff  <= '0;
        end
        else if (w_hs)
        begin
            wready_ff <= 1'b0;
            wdata_ff  <= s_axi_wdata_in;
            wstrb_ff  <= s_axi_wstrb_in;
        end
        else if (bvalid_ff && s_axi_bready_in)
            wready_ff <= 1'b1;
    end

    // Writes to read-only words are ignored but answered OKAY
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= (awaddr_ff > OFS_STATUS || awaddr_ff[1:0] != 2'h0)
                         ? RESP_SLVERR : RESP_OKAY;
        end
        else if (s_axi_bready_in)
            bvalid_ff <= 1'b0;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cfg_ff.full_res  <= FULL_RST;
            cfg_ff.left_just <= JUST_RST;
            cfg_ff.range     <= RANGE_RST;
            cfg_ff.rate      <= RATE_RST;
        end
        else if (wr_fire && wstrb_ff[0])
        begin
            if (awaddr_ff == OFS_FORMAT)
            begin
                cfg_ff.full_res  <= wdata_ff[FMT_FULL_BIT];
                cfg_ff.left_just <= wdata_ff[FMT_JUST_BIT];
                cfg_ff.range     <= wdata_ff[FMT_RANGE_LSB +: 2]; // R8
            end
            else if (awaddr_ff == OFS_RATE)
                cfg_ff.rate <= wdata_ff[RATE_LSB +: 4];
        end
    end

    // Words change only on a new sample, so a read sees one whole sample
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            word_ff <= '{default: '0};
        else if (sample_valid_in)
            word_ff <= nxt_word; // R1 R2 R3 R4 R5 R6 R7
    end

    // A new sample in the clearing cycle wins over the read
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            ready_ff <= 1'b0;
            ovr_ff   <= 1'b0;
        end
        else
        begin
            if (sample_valid_in)
                ready_ff <= 1'b1;
            else if (stat_rd)
                ready_ff <= 1'b0;
            if (sample_valid_in && ready_ff)
                ovr_ff <= 1'b1;
            else if (stat_rd)
                ovr_ff <= 1'b0;
        end
    end

    always_comb
    begin
        rd_data = '0;
        rd_err  = 1'b0;
        if (s_axi_araddr_in == OFS_FORMAT)
        begin
            rd_data[FMT_FULL_BIT]       = cfg_ff.full_res;
            rd_data[FMT_JUST_BIT]       = cfg_ff.left_just;
            rd_data[FMT_RANGE_LSB +: 2] = cfg_ff.range;
        end
        else if (s_axi_araddr_in == OFS_RATE)
            rd_data[RATE_LSB +: 4] = cfg_ff.rate;
        else if (s_axi_araddr_in == OFS_X)
            rd_data[WORD_W-1:0] = word_ff[0];
        else if (s_axi_araddr_in == OFS_Y)
            rd_data[WORD_W-1:0] = word_ff[1];
        else if (s_axi_araddr_in == OFS_Z)
            rd_data[WORD_W-1:0] = word_ff[2];
        else if (s_axi_araddr_in == OFS_STATUS)
        begin
            rd_data[STAT_RDY_BIT] = ready_ff;
            rd_data[STAT_OVR_BIT] = ovr_ff;
        end
        else
            rd_err = 1'b1;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= '0;
            rresp_ff   <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_data;
            rresp_ff   <= rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        else if (rvalid_ff && s_axi_rready_in)
        begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
        end
    end

    assign s_axi_awready_out = awready_ff;
    assign s_axi_wready_out  = wready_ff;
    assign s_axi_bvalid_out  = bvalid_ff;
    assign s_axi_bresp_out   = bresp_ff;
    assign s_axi_arready_out = arready_ff;
    assign s_axi_rvalid_out  = rvalid_ff;
    assign s_axi_rdata_out   = rdata_ff;
    assign s_axi_rresp_out   = rresp_ff;
    assign data_ready_out    = ready_ff;

    // Checks on the x axis word, range code writes and read latency
    logic              hi_rate;
    logic              fits10;
    logic              fits11;
    logic [WORD_W-1:0] exp_rj;
    assign hi_rate = afmt_high_rate(cfg_ff.rate);
    assign fits10  = (raw[0][12:9] == 4'h0) || (raw[0][12:9] == 4'hf);
    assign fits11  = (raw[0][12:10] == 3'h0) || (raw[0][12:10] == 3'h7);
    assign exp_rj  = {{(WORD_W-RAW_W){raw[0][RAW_W-1]}}, raw[0]};
    property p_r1;
        @(posedge clk_in) disable iff (rst_in)
        sample_valid_in && cfg_ff.full_res && !cfg_ff.left_just &&
        !hi_rate && cfg_ff.range == RANGE_MAX
        |=> word_ff[0] == $past(exp_rj);
    endproperty
    a_r1: assert property (p_r1) else $error("full-res word wrong"); // R1
    property p_r2;
        @(posedge clk_in) disable iff (rst_in)
        sample_valid_in && hi_rate && !cfg_ff.left_just &&
        (cfg_ff.full_res || cfg_ff.range == 2'h0)
        |=> word_ff[0][0] == 1'b0 ##1 (word_ff[0][0] == 1'b0 ||
            $past(sample_valid_in));
    endproperty
    a_r2: assert property (p_r2) else $error("lowest bit not zero"); // R2
    property p_r3;
        @(posedge clk_in) disable iff (rst_in)
        sample_valid_in && !cfg_ff.full_res && !cfg_ff.left_just
        |=> word_ff[0][15:9] == {7{word_ff[0][9]}};
    endproperty
    a_r3: assert property (p_r3) else $error("right justify wrong"); // R3
    property p_r4;
        @(posedge clk_in) disable iff (rst_in)
        sample_valid_in && !cfg_ff.full_res && cfg_ff.left_just &&
        cfg_ff.range == 2'h0 && !hi_rate && fits10
        |=> word_ff[0][5:0] == 6'h0 && word_ff[0][6] == $past(raw[0][0]);
    endproperty
    a_r4: assert property (p_r4) else $error("10-bit left lsb wrong"); // R4
    property p_r5;
        @(posedge clk_in) disable iff (rst_in)
        sample_valid_in && cfg_ff.full_res && cfg_ff.left_just &&
        cfg_ff.range == RANGE_MAX && !hi_rate
        |=> word_ff[0] == {$past(raw[0]), 3'h0};
    endproperty
    a_r5: assert property (p_r5) else $error("full-res left wrong"); // R5
    property p_r6;
        @(posedge clk_in) disable iff (rst_in)
        sample_valid_in && hi_rate && !cfg_ff.full_res &&
        !cfg_ff.left_just && cfg_ff.range == 2'h1 && fits11
        |=> word_ff[0][0] == $past(raw[0][1]);
    endproperty
    a_r6: assert property (p_r6) else $error("10-bit lsb forced"); // R6
    property p_r7;
        @(posedge clk_in) disable iff (rst_in)
        sample_valid_in && !hi_rate && !cfg_ff.left_just &&
        cfg_ff.range == 2'h0 && fits10
        |=> word_ff[0][0] == $past(raw[0][0]);
    endproperty
    a_r7: assert property (p_r7) else $error("slow rate lsb lost"); // R7
    property p_r8;
        @(posedge clk_in) disable iff (rst_in)
        wr_fire && wstrb_ff[0] && awaddr_ff == OFS_FORMAT &&
        wdata_ff[FMT_RANGE_LSB +: 2] == RANGE_MAX
        |=> cfg_ff.range == RANGE_MAX && s_axi_bvalid_out;
    endproperty
    a_r8: assert property (p_r8) else $error("range code not taken"); // R8
    property p_rd_latency;
        @(posedge clk_in) disable iff (rst_in)
        ar_hs |=> s_axi_rvalid_out && !s_axi_arready_out;
    endproperty
    a_rd_latency: assert property (p_rd_latency)
        else $error("read answer late");
    c_fullres_left: cover property (@(posedge clk_in) disable iff (rst_in)
        sample_valid_in && cfg_ff.full_res && cfg_ff.left_just);
    c_hi_rate_10b: cover property (@(posedge clk_in) disable iff (rst_in)
        sample_valid_in && hi_rate && !cfg_ff.full_res);
    c_write_read: cover property (@(posedge clk_in) disable iff (rst_in)
        wr_fire ##[1:20] ar_hs);

endmodule // afmt_top

`default_nettype wire

//--- testbench/afmt_host_model.sv
`default_nettype none

module afmt_host_model (
    // Clock
    input  wire logic                        clk_in,
    // Write address and data
    output var  logic                        awvalid_out,
    input  wire logic                        awready_in,
    output var  logic [afmt_pkg::AXI_AW-1:0] awaddr_out,
    output var  logic                        wvalid_out,
    input  wire logic                        wready_in,
    output var  logic [afmt_pkg::AXI_DW-1:0] wdata_out,
    output var  logic [3:0]                  wstrb_out,
    // Write response
    input  wire logic                        bvalid_in,
    output var  logic                        bready_out,
    input  wire logic [1:0]                  bresp_in,
    // Read channels
    output var  logic                        arvalid_out,
    input  wire logic                        arready_in,
    output var  logic [afmt_pkg::AXI_AW-1:0] araddr_out,
    input  wire logic                        rvalid_in,
    output var  logic                        rready_out,
    input  wire logic [afmt_pkg::AXI_DW-1:0] rdata_in,
    input  wire logic [1:0]                  rresp_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import afmt_pkg::*;

    initial
    begin
        {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = '0;
        awaddr_out = '0;
        wdata_out  = '0;
        wstrb_out  = '0;
        araddr_out = '0;
    end

    // Released addresses and write data show the inverse (the strobe keeps its value) so stale values never match
    task automatic wr(input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] d,
                      input logic [3:0] s, output logic [1:0] resp);
        bit aw_done;
        bit w_done;
        aw_done = 0;
        w_done  = 0;
        @(posedge clk_in);
        awvalid_out <= 1'b1;
        awaddr_out  <= a;
        wvalid_out  <= 1'b1;
        wdata_out   <= d;
        wstrb_out   <= s;
        bready_out  <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge clk_in);
            if (!aw_done && awready_in === 1'b1)
            begin
                aw_done = 1;
                awvalid_out <= 1'b0;
                awaddr_out  <= ~a;
            end
            if (!w_done && wready_in === 1'b1)
            begin
                w_done = 1;
                wvalid_out <= 1'b0;
                wdata_out  <= ~d;
            end
        end
        do @(posedge clk_in); while (bvalid_in !== 1'b1);
        resp = bresp_in;
        bready_out <= 1'b0;
    endtask

    task automatic rd(input logic [AXI_AW-1:0] a, output logic [AXI_DW-1:0] d,
                      output logic [1:0] resp);
        @(posedge clk_in);
        arvalid_out <= 1'b1;
        araddr_out  <= a;
        rready_out  <= 1'b1;
        do @(posedge clk_in); while (arready_in !== 1'b1);
        arvalid_out <= 1'b0;
        araddr_out  <= ~a;
        while (rvalid_in !== 1'b1) @(posedge clk_in);
        d    = rdata_in;
        resp = rresp_in;
        rready_out <= 1'b0;
    endtask
endmodule // afmt_host_model

`default_nettype wire

//--- testbench/afmt_top_tb.sv
`default_nettype none

module afmt_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import afmt_pkg::*;

    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic sample_valid = 1'b0;
    afmt_sample_t sample = '0;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, data_ready;
    logic [AXI_AW-1:0] awaddr, araddr;
    logic [AXI_DW-1:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int n_mismatch = 0;
    int check_count = 0;

    always #5 clk_in = ~clk_in;

    afmt_top dut (.clk_in(clk_in), .rst_in(rst_in),
        .sample_valid_in(sample_valid), .sample_in(sample),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .data_ready_out(data_ready));

    afmt_host_model host (.clk_in(clk_in), .awvalid_out(awvalid),
        .awready_in(awready), .awaddr_out(awaddr), .wvalid_out(wvalid),
        .wready_in(wready), .wdata_out(wdata), .wstrb_out(wstrb),
        .bvalid_in(bvalid), .bready_out(bready), .bresp_in(bresp),
        .arvalid_out(arvalid), .arready_in(arready), .araddr_out(araddr),
        .rvalid_in(rvalid), .rready_out(rready), .rdata_in(rdata),
        .rresp_in(rresp));

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
                           input string what);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk_val({30'h0, got}, {30'h0, exp}, "response");
    endtask

    // Reference word, worked out independently of the design
    function automatic logic [15:0] exp_word(input logic signed [12:0] raw,
        input logic fr, input logic lj, input logic [1:0] rg,
        input logic [3:0] rate);
        int w;
        int v;
        w = fr ? 10 + rg : 10;
        v = raw;
        if (!fr)
            v = v >>> rg;
        if (v > (1 << (w - 1)) - 1)
            v = (1 << (w - 1)) - 1;
        if (v < -(1 << (w - 1)))
            v = -(1 << (w - 1));
        if ((rate == RATE_3200 || rate == RATE_1600) && (fr || rg == 2'h0))
            v = v & ~1;
        return lj ? 16'(v << (16 - w)) : 16'(v);
    endfunction

    task automatic push(input logic signed [12:0] x, y, z);
        @(posedge clk_in);
        sample_valid <= 1'b1;
        sample <= '{x: x, y: y, z: z};
        @(posedge clk_in);
        sample_valid <= 1'b0;
        sample <= ~sample;
        @(negedge clk_in);
    endtask

    task automatic test_reset;
        logic [31:0] d;
        logic [1:0] r;
        chk_val({31'h0, data_ready}, 32'h0, "ready after reset");
        host.rd(OFS_FORMAT, d, r);
        chk_val(d, 32'h0, "format reset");
        host.rd(OFS_RATE, d, r);
        chk_val(d, {28'h0, RATE_RST}, "rate reset");
        host.rd(OFS_X, d, r);
        chk_val(d, 32'h0, "x reset");
        $display("test reset done");
    endtask

    // Every mode, justification, range and two low and both high rates
    task automatic test_formats;
        logic [3:0] rates [4] = '{4'hf, 4'he, 4'hd, 4'ha};
        logic signed [12:0] raw [3] = '{13'sh0aab, -13'sd1, 13'sh0555};
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] ofs [3] = '{OFS_X, OFS_Y, OFS_Z};
        for (int c = 0; c < 64; c++)
        begin
            host.wr(OFS_FORMAT, {28'h0, 4'(c >> 2)}, 4'hf, r);
            chk_resp(r, RESP_OKAY);
            host.wr(OFS_RATE, {28'h0, rates[c % 4]}, 4'hf, r);
            push(raw[0], raw[1], raw[2]);
            for (int a = 0; a < 3; a++)
            begin
                host.rd(ofs[a], d, r);
                chk_val(d, {16'h0, exp_word(raw[a], c[5], c[4], c[3:2],
                        rates[c % 4])}, "word");
            end
        end
        $display("test formats done");
    endtask

    task automatic test_bus_errors;
        logic [31:0] d;
        logic [1:0] r;
        host.wr(8'h18, 32'h1, 4'hf, r);
        chk_resp(r, RESP_SLVERR);
        host.rd(8'h18, d, r);
        chk_resp(r, RESP_SLVERR);
        host.wr(OFS_FORMAT, 32'h0, 4'hf, r);
        host.wr(OFS_RATE, 32'ha, 4'hf, r);
        push(13'sh0011, 13'sh0022, 13'sh0033);
        host.wr(OFS_X, 32'hffff, 4'hf, r);
        chk_resp(r, RESP_OKAY);
        host.rd(OFS_X, d, r);
        chk_val(d, 32'h11, "x read only");
        host.wr(OFS_FORMAT, 32'hf, 4'h0, r);
        host.rd(OFS_FORMAT, d, r);
        chk_val(d, 32'h0, "strobe off ignored");
        $display("test bus errors done");
    endtask

    task automatic test_status;
        logic [31:0] d;
        logic [1:0] r;
        host.rd(OFS_STATUS, d, r);
        push(13'sh0001, 13'sh0002, 13'sh0003);
        push(13'sh0004, 13'sh0005, 13'sh0006);
        chk_val({31'h0, data_ready}, 32'h1, "ready level");
        host.rd(OFS_STATUS, d, r);
        chk_val(d, 32'h3, "ready and overrun");
        host.rd(OFS_STATUS, d, r);
        chk_val(d, 32'h0, "status cleared");
        @(negedge clk_in);
        chk_val({31'h0, data_ready}, 32'h0, "ready cleared");
        $display("test status done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Whole run needs under 3000 cycles; allow several times that
    initial
    begin
        #200us;
        n_mismatch++;
        report_and_stop();
    end

    initial
    begin
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        @(negedge clk_in);
        test_reset();
        test_formats();
        test_bus_errors();
        test_status();
        report_and_stop();
    end
endmodule // afmt_top_tb

`default_nettype wire
